//--- igd_top.sv
// Top of the IDE and game-port select decoder; every output is registered.
// Assumes host pins are asynchronous and pass a two-stage synchroniser here.
module igd_top
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       supply_valid,
    input  wire logic [9:0] host_addr,
    input  wire logic       host_aen,
    input  wire logic       host_rd_n,
    input  wire logic       host_wr_n,
    input  wire logic       host_d7_in,
    input  wire logic       wide_transfer_indicator_n,
    input  wire logic       drive_data_bit7_in,
    input  wire logic       disk_change,
    input  wire logic       cfg_ide_enable,
    input  wire logic       cfg_primary,
    input  wire logic       cfg_wide_host_mode,
    input  wire logic       second_uart_strap0,
    input  wire logic       second_uart_strap1,
    input  wire logic       disk_address_strap,
    input  wire logic       floppy_address_strap,
    input  wire logic       printer_port_mode_strap,
    output logic            ide_upper_lane_enable_n,
    output logic            ide_upper_lane_oe,
    output logic            ide_lower_lane_enable_n,
    output logic            ide_lower_lane_oe,
    output logic            disk_task_select_n,
    output logic            disk_task_oe,
    output logic            disk_control_select_n,
    output logic            disk_control_oe,
    output logic            joystick_port_select_n,
    output logic            joystick_port_oe,
    output logic            drive_data_bit7_out,
    output logic            drive_data_bit7_oe,
    output logic            host_d7_out,
    output logic            host_d7_oe,
    output logic            disk_dma_ack_n,
    output logic [1:0]      second_uart_strap,
    output logic            disk_address_latched,
    output logic            floppy_address_latched,
    output logic            printer_port_mode_latched,
    output logic            standby
);
    localparam int unsigned NSYNC = 21;

    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] sync_in;

    assign sync_in = {supply_valid, host_addr, host_aen, host_rd_n, host_wr_n, host_d7_in,
                      wide_transfer_indicator_n, drive_data_bit7_in, disk_change,
                      cfg_ide_enable, cfg_primary, cfg_wide_host_mode};

    // Reset values keep the strobes inactive so nothing decodes right after release.
    localparam logic [NSYNC-1:0] SYNC_RST = 21'h0003a0;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
        end
        else
        begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic       s_pwr;
    logic [9:0] s_addr;
    logic       s_aen;
    logic       s_rd_n;
    logic       s_wr_n;
    logic       s_host_d7;
    logic       s_wide_n;
    logic       s_drv_d7;
    logic       s_chg;
    logic       s_ide;
    logic       s_pri;
    logic       s_wide;

    assign {s_pwr, s_addr, s_aen, s_rd_n, s_wr_n, s_host_d7, s_wide_n, s_drv_d7, s_chg,
            s_ide, s_pri, s_wide} = sync2_reg;

    // Straps: sampled every reset cycle, held afterwards.
    logic [4:0] strap_reg;
    logic [4:0] strap_next;

    always_comb
    begin
        strap_next = strap_reg;
        if (!rstn)
        begin
            strap_next = {second_uart_strap1, second_uart_strap0, disk_address_strap,
                          floppy_address_strap, printer_port_mode_strap};
        end
    end

    always_ff @(posedge core_clk)
    begin
        strap_reg <= strap_next;
    end

    // State machine: reset, running, or standby while supply is invalid.
    igd_pkg::igd_state_t state_reg;
    igd_pkg::igd_state_t state_next;

    always_comb
    begin
        case (state_reg)
            igd_pkg::IGD_ST_RESET: state_next = s_pwr ? igd_pkg::IGD_ST_RUN
                                                      : igd_pkg::IGD_ST_SLEEP;
            igd_pkg::IGD_ST_RUN:   state_next = s_pwr ? igd_pkg::IGD_ST_RUN
                                                      : igd_pkg::IGD_ST_SLEEP;
            igd_pkg::IGD_ST_SLEEP: state_next = s_pwr ? igd_pkg::IGD_ST_RUN
                                                      : igd_pkg::IGD_ST_SLEEP;
            default:               state_next = igd_pkg::IGD_ST_RESET;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            state_reg <= igd_pkg::IGD_ST_RESET;
        else
            state_reg <= state_next;
    end

    logic run;
    assign run = (state_reg == igd_pkg::IGD_ST_RUN);

    igd_if dif ();

    // Effective config: the disk address strap flips the primary choice.
    always_comb
    begin
        dif.addr      = s_addr;
        dif.aen       = s_aen | !run;
        dif.rd_n      = s_rd_n;
        dif.wr_n      = s_wr_n;
        dif.wide_n    = s_wide_n;
        dif.ide_on    = s_ide;
        dif.primary   = s_pri ^ strap_reg[2];
        dif.wide_mode = s_wide;
    end

    igd_decode u_dec
    (
        .bus (dif)
    );

    // Output registers: select values freeze in standby while every enable drops.
    logic [15:0] out_reg;
    logic [15:0] out_next;

    always_comb
    begin
        out_next = out_reg;
        if (run)
        begin
            out_next[0]  = !dif.upper_hit;
            out_next[1]  = !(dif.task_hit || (s_wide && dif.ctrl_hit));
            out_next[2]  = !dif.task_hit;
            out_next[3]  = !dif.ctrl_hit;
            out_next[4]  = !dif.joy_hit;
            out_next[5]  = s_host_d7;
            out_next[6]  = dif.d7_change ? s_chg : s_drv_d7;
            out_next[9]  = s_wide ? igd_pkg::SEL_IDLE_N : s_wide_n;
        end
        // Enables and standby are gated here so that each output pin comes straight from a flop.
        out_next[7]  = run && dif.d7_fwd;
        out_next[8]  = run && (dif.d7_back || dif.d7_change);
        out_next[10] = run;
        out_next[11] = run && s_wide;
        out_next[12] = !run;
        out_next[15:13] = 3'h0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            out_reg <= 16'h121f;
        else
            out_reg <= out_next;
    end

    assign ide_upper_lane_enable_n   = out_reg[0];
    assign ide_upper_lane_oe         = out_reg[11];
    assign ide_lower_lane_enable_n   = out_reg[1];
    assign ide_lower_lane_oe         = out_reg[10];
    assign disk_task_select_n        = out_reg[2];
    assign disk_task_oe              = out_reg[10];
    assign disk_control_select_n     = out_reg[3];
    assign disk_control_oe           = out_reg[10];
    assign joystick_port_select_n    = out_reg[4];
    assign joystick_port_oe          = out_reg[10];
    assign drive_data_bit7_out       = out_reg[5];
    assign drive_data_bit7_oe        = out_reg[7];
    assign host_d7_out               = out_reg[6];
    assign host_d7_oe                = out_reg[8];
    assign disk_dma_ack_n            = out_reg[9];
    assign second_uart_strap         = strap_reg[4:3];
    assign disk_address_latched      = strap_reg[2];
    assign floppy_address_latched    = strap_reg[1];
    assign printer_port_mode_latched = strap_reg[0];
    assign standby                   = out_reg[12];
endmodule : igd_top

//--- igd_pkg.sv
// Package for the IDE and game-port chip-select decoder.
// Assumes a 10-bit host I/O address and a single 250 MHz core clock.
package igd_pkg;
    localparam int unsigned ADDR_W = 10;

    localparam logic [9:0] PRI_TASK_BASE  = 10'h1f0;
    localparam logic [9:0] SEC_TASK_BASE  = 10'h170;
    localparam logic [9:0] NAR_TASK_BASE  = 10'h320;
    localparam logic [9:0] PRI_CTRL_LO    = 10'h3f6;
    localparam logic [9:0] PRI_CTRL_HI    = 10'h3f7;
    localparam logic [9:0] SEC_CTRL_LO    = 10'h376;
    localparam logic [9:0] SEC_CTRL_HI    = 10'h377;
    localparam logic [9:0] NAR_CTRL_LO    = 10'h3f5;
    localparam logic [9:0] JOY_ADDR       = 10'h201;

    localparam logic       STRAP_RESET    = 1'b0;
    localparam logic       SEL_IDLE_N     = 1'b1;

    typedef enum logic [2:0]
    {
        IGD_ST_RESET = 3'b001,
        IGD_ST_RUN   = 3'b010,
        IGD_ST_SLEEP = 3'b100
    } igd_state_t;
endpackage : igd_pkg

//--- igd_if.sv
// Interface carrying synchronised host-cycle and configuration signals.
// Assumes both ends run on core_clk.
interface igd_if;
    logic [9:0] addr;
    logic       aen;
    logic       rd_n;
    logic       wr_n;
    logic       wide_n;
    logic       ide_on;
    logic       primary;
    logic       wide_mode;
    logic       task_hit;
    logic       ctrl_hit;
    logic       upper_hit;
    logic       joy_hit;
    logic       d7_fwd;
    logic       d7_back;
    logic       d7_change;

    modport top
    (
        output addr, aen, rd_n, wr_n, wide_n, ide_on, primary, wide_mode,
        input  task_hit, ctrl_hit, upper_hit, joy_hit, d7_fwd, d7_back, d7_change
    );
    modport dec
    (
        input  addr, aen, rd_n, wr_n, wide_n, ide_on, primary, wide_mode,
        output task_hit, ctrl_hit, upper_hit, joy_hit, d7_fwd, d7_back, d7_change
    );
endinterface : igd_if

//--- igd_decode.sv
// Combinational address decode for the IDE and game-port selects.
// Assumes its inputs are already synchronised to core_clk.
module igd_decode
(
    igd_if.dec bus
);
    function automatic logic in_range(input logic [9:0] a, input logic [9:0] lo,
                                      input logic [9:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    logic io_ok;
    logic pri_task;
    logic sec_task;
    logic nar_task;
    logic pri_ctrl;
    logic sec_ctrl;
    logic nar_ctrl;
    logic rd;
    logic wr;

    always_comb
    begin
        rd       = !bus.rd_n;
        wr       = !bus.wr_n;
        io_ok    = !bus.aen && (rd || wr);
        pri_task = in_range(bus.addr, igd_pkg::PRI_TASK_BASE, igd_pkg::PRI_TASK_BASE + 10'h007);
        sec_task = in_range(bus.addr, igd_pkg::SEC_TASK_BASE, igd_pkg::SEC_TASK_BASE + 10'h007);
        nar_task = in_range(bus.addr, igd_pkg::NAR_TASK_BASE, igd_pkg::NAR_TASK_BASE + 10'h003);
        pri_ctrl = in_range(bus.addr, igd_pkg::PRI_CTRL_LO, igd_pkg::PRI_CTRL_HI);
        sec_ctrl = in_range(bus.addr, igd_pkg::SEC_CTRL_LO, igd_pkg::SEC_CTRL_HI);
        // The narrow control window decodes 3F6-3F7 only, the same range as the select; NAR_CTRL_LO (3F5) is unused.
        nar_ctrl = in_range(bus.addr, igd_pkg::PRI_CTRL_LO, igd_pkg::PRI_CTRL_HI);
        if (bus.wide_mode)
        begin
            bus.task_hit = io_ok && bus.ide_on && (bus.primary ? pri_task : sec_task);
            bus.ctrl_hit = io_ok && bus.ide_on && (bus.primary ? pri_ctrl : sec_ctrl);
        end
        else
        begin
            bus.task_hit = io_ok && bus.ide_on && nar_task;
            bus.ctrl_hit = io_ok && bus.ide_on && nar_ctrl;
        end
        bus.upper_hit = bus.wide_mode && !bus.wide_n
                        && io_ok && bus.ide_on && (bus.primary ? pri_task : sec_task);
        bus.joy_hit   = io_ok && (bus.addr == igd_pkg::JOY_ADDR);
        bus.d7_fwd    = bus.wide_mode && bus.ide_on && wr && io_ok && bus.primary
                        && (pri_task || pri_ctrl);
        bus.d7_back   = bus.wide_mode && bus.ide_on && rd && io_ok && bus.primary
                        && (pri_task || bus.addr == igd_pkg::PRI_CTRL_LO);
        bus.d7_change = rd && io_ok && (bus.addr == igd_pkg::PRI_CTRL_HI);
    end
endmodule : igd_decode

//--- igd_top_props.sv
// Timing and decode checks on the select decoder pins.
// Assumes inputs held still for six edges have reached the outputs.
module igd_top_props
(
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       supply_valid,
    input wire logic [9:0] host_addr,
    input wire logic       host_aen,
    input wire logic       host_rd_n,
    input wire logic       host_wr_n,
    input wire logic       host_d7_in,
    input wire logic       wide_transfer_indicator_n,
    input wire logic       disk_change,
    input wire logic       cfg_ide_enable,
    input wire logic       cfg_primary,
    input wire logic       cfg_wide_host_mode,
    input wire logic       ide_upper_lane_enable_n,
    input wire logic       ide_lower_lane_enable_n,
    input wire logic       disk_task_select_n,
    input wire logic       disk_task_oe,
    input wire logic       disk_control_select_n,
    input wire logic       joystick_port_select_n,
    input wire logic       drive_data_bit7_out,
    input wire logic       drive_data_bit7_oe,
    input wire logic       host_d7_out,
    input wire logic       host_d7_oe,
    input wire logic       disk_dma_ack_n,
    input wire logic [1:0] second_uart_strap,
    input wire logic       disk_address_latched,
    input wire logic       standby
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] snap_reg;
    logic [2:0]  cnt_reg;
    logic [2:0]  cnt_next;
    wire logic [19:0] now = {host_addr, host_aen, host_rd_n, host_wr_n, host_d7_in,
                             wide_transfer_indicator_n, disk_change, cfg_ide_enable,
                             cfg_primary, cfg_wide_host_mode, supply_valid};
    // Checks wait for settled inputs because the pins pass a synchroniser first.
    // The snapshot compare drops a check on the very edge at which an input has just moved.
    wire logic settled = cnt_reg >= 3'h6 && now == snap_reg && supply_valid;
    wire logic wide = cfg_wide_host_mode;
    wire logic pri = cfg_primary ^ disk_address_latched;
    wire logic io = !host_aen && !(host_rd_n && host_wr_n);
    wire logic ok = io && cfg_ide_enable;
    wire logic t_hit = wide ? host_addr[9:3] == (pri ? 7'h3e : 7'h2e) : host_addr[9:2] == 8'hc8;
    wire logic c_hit = host_addr[9:1] == ((wide && !pri) ? 9'h1bb : 9'h1fb);
    always_comb
    begin
        cnt_next = (now != snap_reg) ? 3'h0 : cnt_reg + {2'h0, cnt_reg != 3'h7};
    end
    always_ff @(posedge core_clk)
    begin
        snap_reg <= now;
        cnt_reg  <= rstn ? cnt_next : 3'h0;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence supply_lost;
        !supply_valid [*5];
    endsequence
    task_select_a: assert property (settled |-> disk_task_select_n == !(ok && t_hit))
        else $error("task select wrong");
    ctrl_select_a: assert property (settled |-> disk_control_select_n == !(ok && c_hit))
        else $error("control select wrong");
    lower_lane_a: assert property (settled |->
        ide_lower_lane_enable_n == !(ok && (t_hit || (wide && c_hit)))) else $error("lower lane wrong");
    upper_lane_a: assert property (settled |->
        ide_upper_lane_enable_n == !(ok && wide && t_hit && !wide_transfer_indicator_n))
        else $error("upper lane wrong");
    joy_select_a: assert property (settled |-> joystick_port_select_n == !(io && host_addr == 10'h201))
        else $error("joystick select wrong");
    disk_change_a: assert property (settled && ok && wide && !host_rd_n && host_addr == 10'h3f7
        |-> host_d7_oe && host_d7_out == disk_change) else $error("disk change bit wrong");
    write_bit7_a: assert property (settled && ok && wide && pri && (t_hit || c_hit) && !host_wr_n
        |-> drive_data_bit7_oe && drive_data_bit7_out == host_d7_in) else $error("bit 7 write wrong");
    dma_ack_a: assert property (settled |-> disk_dma_ack_n == (wide || wide_transfer_indicator_n))
        else $error("dma acknowledge wrong");
    standby_float_a: assert property (supply_lost |-> standby && !disk_task_oe && !host_d7_oe
        && !drive_data_bit7_oe) else $error("outputs driven in standby");
    strap_hold_a: assert property ($past(rstn) && $past(rstn, 2) |->
        $stable(second_uart_strap) && $stable(disk_address_latched)) else $error("strap changed");
endmodule : igd_top_props

bind igd_top igd_top_props u_props (.*);

//--- igd_drive_model.sv
// Behavioural IDE drive standing on the far side of the decoder.
// Assumes the bench connects it to the decoder pins by name.
module igd_drive_model
(
    input  wire logic core_clk,
    input  wire logic cfg_wide_host_mode,
    input  wire logic req16,
    input  wire logic dma_req,
    input  wire logic disk_task_select_n,
    input  wire logic disk_control_select_n,
    input  wire logic drive_data_bit7_oe,
    input  wire logic drive_data_bit7_out,
    output logic      wide_transfer_indicator_n,
    output logic      drive_data_bit7_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_reg = 1'b0;
    wire logic hit = !(disk_task_select_n && disk_control_select_n);
    assign wide_transfer_indicator_n = cfg_wide_host_mode ?
        !(req16 && !disk_task_select_n) : !dma_req;
    // An unselected drive toggles bit 7 so that a stale level never passes for data.
    assign drive_data_bit7_in = drive_data_bit7_oe ? drive_data_bit7_out : (hit ? 1'b1 : !last_reg);
    always_ff @(posedge core_clk) last_reg <= drive_data_bit7_in;
endmodule : igd_drive_model

//--- igd_top_test.sv
// Directed bench for the select decoder with a behavioural drive.
// Assumes the decoder answers within eight edges of a held input.
module igd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk = 1'b0, rstn = 1'b0, supply_valid = 1'b1, host_aen = 1'b0;
    logic [9:0] host_addr = 10'h000;
    logic       host_rd_n = 1'b1, host_wr_n = 1'b1, host_d7_in = 1'b1, disk_change = 1'b0;
    logic       cfg_ide_enable = 1'b1, cfg_primary = 1'b0, cfg_wide_host_mode = 1'b1;
    logic       second_uart_strap0 = 1'b1, second_uart_strap1 = 1'b0, disk_address_strap = 1'b1;
    logic       floppy_address_strap = 1'b1, printer_port_mode_strap = 1'b0;
    logic       req16 = 1'b1, dma_req = 1'b0, wide_transfer_indicator_n, drive_data_bit7_in;
    logic       ide_upper_lane_enable_n, ide_upper_lane_oe, ide_lower_lane_enable_n;
    logic       ide_lower_lane_oe, disk_task_select_n, disk_task_oe, disk_control_select_n;
    logic       disk_control_oe, joystick_port_select_n, joystick_port_oe, drive_data_bit7_out;
    logic       drive_data_bit7_oe, host_d7_out, host_d7_oe, disk_dma_ack_n, standby;
    logic       disk_address_latched, floppy_address_latched, printer_port_mode_latched;
    logic [1:0] second_uart_strap;
    int         fail_count = 0, n_tests = 0;
    always #2 core_clk = ~core_clk;
    igd_top dut (.*);
    igd_drive_model disk (.*);
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task conclude;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // Expected bits: task, control, upper, lower, joystick, host bit 7 oe, drive bit 7 oe.
    task acc(input logic [9:0] a, input logic rd, input logic [6:0] e, input logic d7);
        @(posedge core_clk);
        host_addr <= a;
        host_rd_n <= !rd;
        host_wr_n <= rd;
        repeat (8) @(posedge core_clk);
        #1;
        chk({1'b0, ~disk_task_select_n, ~disk_control_select_n, ~ide_upper_lane_enable_n,
             ~ide_lower_lane_enable_n, ~joystick_port_select_n, host_d7_oe, drive_data_bit7_oe},
            {1'b0, e});
        if (e[1])
            chk({7'h00, host_d7_out}, {7'h00, d7});
        if (e[0])
            chk({7'h00, drive_data_bit7_out}, {7'h00, host_d7_in});
        @(posedge core_clk);
        host_rd_n <= 1'b1;
        host_wr_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : acc
    initial
    begin
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        second_uart_strap0 <= 1'b0;
        disk_address_strap <= 1'b0;
        printer_port_mode_strap <= 1'b1;
        acc(10'h1f0, 1'b1, 7'h5a, 1'b1);
        host_d7_in <= 1'b0;
        acc(10'h1f7, 1'b0, 7'h59, 1'b0);
        acc(10'h3f6, 1'b1, 7'h2a, 1'b1);
        acc(10'h3f7, 1'b1, 7'h2a, 1'b0);
        host_d7_in <= 1'b1;
        acc(10'h3f7, 1'b0, 7'h29, 1'b0);
        acc(10'h1f8, 1'b1, 7'h00, 1'b0);
        acc(10'h3f5, 1'b1, 7'h00, 1'b0);
        acc(10'h201, 1'b1, 7'h04, 1'b0);
        host_aen <= 1'b1;
        acc(10'h1f0, 1'b1, 7'h00, 1'b0);
        host_aen <= 1'b0;
        cfg_ide_enable <= 1'b0;
        acc(10'h1f0, 1'b1, 7'h00, 1'b0);
        cfg_ide_enable <= 1'b1;
        req16 <= 1'b0;
        acc(10'h1f0, 1'b1, 7'h4a, 1'b1);
        cfg_primary <= 1'b1;
        acc(10'h177, 1'b1, 7'h48, 1'b0);
        acc(10'h376, 1'b0, 7'h28, 1'b0);
        acc(10'h1f0, 1'b1, 7'h00, 1'b0);
        cfg_wide_host_mode <= 1'b0;
        acc(10'h320, 1'b1, 7'h48, 1'b0);
        acc(10'h323, 1'b0, 7'h48, 1'b0);
        acc(10'h324, 1'b1, 7'h00, 1'b0);
        acc(10'h3f6, 1'b1, 7'h20, 1'b0);
        acc(10'h3f7, 1'b0, 7'h20, 1'b0);
        dma_req <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        chk({6'h00, ide_upper_lane_oe, disk_dma_ack_n}, 8'h00);
        @(posedge core_clk);
        dma_req <= 1'b0;
        cfg_wide_host_mode <= 1'b1;
        cfg_primary <= 1'b0;
        host_addr <= 10'h1f0;
        host_rd_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        supply_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
        host_addr <= 10'h201;
        repeat (4) @(posedge core_clk);
        #1;
        chk({standby, disk_task_oe, host_d7_oe, disk_task_select_n, ide_upper_lane_oe,
             ide_lower_lane_oe, disk_control_oe, joystick_port_oe}, 8'h80);
        @(posedge core_clk);
        host_addr <= 10'h1f0;
        supply_valid <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        chk({standby, disk_task_oe, host_d7_oe, disk_task_select_n, ide_upper_lane_oe,
             ide_lower_lane_oe, disk_control_oe, joystick_port_oe}, 8'h6f);
        chk({3'h0, second_uart_strap, disk_address_latched, floppy_address_latched,
             printer_port_mode_latched}, 8'h0e);
        conclude();
    end
endmodule : igd_top_test
